// ==== rtl/gsf_pkg.sv ====
// shared constants and types for the genset fault supervisor
package gsf_pkg;

    // ------------------------------------------------------------
    // clock and timer base
    // ------------------------------------------------------------
    localparam int unsigned CLK_HZ = 50_000_000;
    localparam int unsigned TICK_HZ = 1_000;
    localparam int unsigned MS_TICK_CYC = CLK_HZ / TICK_HZ;
    localparam int unsigned TICK_W = 16;
    localparam int unsigned TMR_W = 16;
    localparam int unsigned MEAS_W = 16;
    localparam int unsigned ACC_W = 32;
    localparam int unsigned ATT_W = 4;
    localparam int unsigned SVC_N = 3;

    // ------------------------------------------------------------
    // fixed timeouts
    // ------------------------------------------------------------
    localparam int unsigned ECU_TIMEOUT_S = 3;
    localparam int unsigned ECU_TIMEOUT_MS = ECU_TIMEOUT_S * 1000;
    localparam int unsigned BTN_HOLD_S = 5;
    localparam int unsigned BTN_HOLD_MS = BTN_HOLD_S * 1000;

    // ------------------------------------------------------------
    // types
    // ------------------------------------------------------------
    typedef struct packed {
        logic [MEAS_W-1:0] l1;
        logic [MEAS_W-1:0] l2;
        logic [MEAS_W-1:0] l3;
    } gsf_phase_s;

    typedef struct packed {
        logic chg_low;
        logic ecu_fail;
        logic volt_unbal;
        logic curr_unbal;
        logic overcurr;
        logic spd_loss;
        logic start_fail;
        logic svc_req;
    } gsf_alarm_s;

    typedef enum logic [1:0] {
        ACT_NONE = 2'h0,
        ACT_WARN = 2'h1,
        ACT_STOP = 2'h2,
        ACT_DUMP = 2'h3
    } gsf_act_e;

    typedef enum logic [1:0] {
        BTN_IDLE = 2'h0,
        BTN_FIRE = 2'h1,
        BTN_WAIT = 2'h3
    } gsf_btn_e;

    // ------------------------------------------------------------
    // reset values
    // ------------------------------------------------------------
    localparam gsf_alarm_s ALARM_RST = '0;
    localparam logic [ACC_W-1:0] ACC_RST = '0;
    localparam logic [ATT_W-1:0] ATT_RST = '0;
    localparam logic [TMR_W-1:0] TMR_RST = '0;

endpackage

// ==== rtl/gsf_persist.sv ====
// persistence timer: level output once a condition held long enough
`timescale 1ns/100ps
`default_nettype none
module gsf_persist
    import gsf_pkg::*;
(
    input wire logic i_sys_clk,
    input wire logic i_nrst,
    input wire logic i_tick,
    input wire logic i_cond,
    input wire logic [TMR_W-1:0] i_limit,
    output logic o_done
);

    logic [TMR_W-1:0] cnt_ff;
    logic [TMR_W-1:0] nxt_cnt;
    logic done_ff;
    logic nxt_done;

    // ------------------------------------------------------------
    // count ms ticks while the condition holds
    // ------------------------------------------------------------
    always_comb begin
        nxt_cnt = cnt_ff;
        if (!i_cond) begin
            nxt_cnt = TMR_RST;
        end else if (i_tick && cnt_ff < i_limit) begin
            nxt_cnt = cnt_ff + TMR_W'(1);
        end
        nxt_done = i_cond && (nxt_cnt >= i_limit);
    end

    always_ff @(posedge i_sys_clk or negedge i_nrst) begin
        if (!i_nrst) begin
            cnt_ff <= TMR_RST;
            done_ff <= 1'b0;
        end else begin
            cnt_ff <= nxt_cnt;
            done_ff <= nxt_done;
        end
    end

    assign o_done = done_ff;

    persist_rst_a: assert property (
        @(posedge i_sys_clk) disable iff (!i_nrst)
        !i_cond |=> (cnt_ff == TMR_RST) && !o_done)
        else $error("persistence timer did not restart");

    persist_hold_a: assert property (
        @(posedge i_sys_clk) disable iff (!i_nrst)
        $rose(o_done) |-> $past(i_cond) && (cnt_ff >= $past(i_limit)))
        else $error("persistence timer expired early");

endmodule // gsf_persist
`default_nettype wire

// ==== rtl/gsf_supervisor.sv ====
// genset fault supervisor: limit checks, delays and sticky alarms
`timescale 1ns/100ps
`default_nettype none
module gsf_supervisor
    import gsf_pkg::*;
#(
    parameter logic [TICK_W-1:0] TICK_CYC = TICK_W'(MS_TICK_CYC)
) (
    input wire logic i_sys_clk,
    input wire logic i_nrst,
    input wire logic i_alarm_clr,
    input wire logic i_eng_running,
    input wire logic i_fuel_on,
    input wire logic i_ecu_msg,
    input wire logic i_crank_end,
    input wire logic [MEAS_W-1:0] i_chg_volt,
    input wire logic [MEAS_W-1:0] i_chg_low_lim,
    input wire gsf_phase_s i_ph_volt,
    input wire gsf_phase_s i_ph_curr,
    input wire logic [MEAS_W-1:0] i_dev_lim,
    input wire logic [MEAS_W-1:0] i_oc_thr,
    input wire logic [ACC_W-1:0] i_oc_curve,
    input wire logic [MEAS_W-1:0] i_rpm,
    input wire logic [MEAS_W-1:0] i_crank_cut_rpm,
    input wire logic [TMR_W-1:0] i_holdoff_ms,
    input wire logic [TMR_W-1:0] i_unbal_ms,
    input wire logic [TMR_W-1:0] i_spd_loss_ms,
    input wire logic [ATT_W-1:0] i_start_max,
    input wire logic [SVC_N-1:0] i_svc_expired,
    input wire logic [1:0] i_btn_n,
    input wire gsf_act_e i_act_cunb,
    input wire gsf_act_e i_act_oc,
    input wire gsf_act_e i_act_spd,
    output gsf_alarm_s o_alarm,
    output logic o_warning,
    output logic o_load_dump,
    output logic o_shutdown,
    output logic o_svc_clear
);

    // ------------------------------------------------------------
    // helpers
    // ------------------------------------------------------------
    // true when 3*x is further than 3*lim from the phase sum
    function automatic logic far_off(
        input logic [MEAS_W-1:0] x,
        input logic [MEAS_W+1:0] sum,
        input logic [MEAS_W+1:0] lim3
    );
        logic [MEAS_W+1:0] x3;
        x3 = (MEAS_W+2)'(x) * (MEAS_W+2)'(3);
        far_off = (x3 > sum) ? ((x3 - sum) > lim3) : ((sum - x3) > lim3);
    endfunction

    function automatic logic dev_over(
        input gsf_phase_s p,
        input logic [MEAS_W-1:0] lim
    );
        logic [MEAS_W+1:0] sum;
        logic [MEAS_W+1:0] lim3;
        sum = (MEAS_W+2)'(p.l1) + (MEAS_W+2)'(p.l2) + (MEAS_W+2)'(p.l3);
        lim3 = (MEAS_W+2)'(lim) * (MEAS_W+2)'(3);
        dev_over = far_off(p.l1, sum, lim3) || far_off(p.l2, sum, lim3)
                || far_off(p.l3, sum, lim3);
    endfunction

    // maximum phase excess over the threshold, zero when none
    function automatic logic [MEAS_W-1:0] excess(
        input gsf_phase_s p,
        input logic [MEAS_W-1:0] thr
    );
        logic [MEAS_W-1:0] m;
        m = p.l1;
        if (p.l2 > m) begin
            m = p.l2;
        end
        if (p.l3 > m) begin
            m = p.l3;
        end
        excess = (m > thr) ? m - thr : '0;
    endfunction

    // ------------------------------------------------------------
    // millisecond tick
    // ------------------------------------------------------------
    logic [TICK_W-1:0] tick_cnt_ff;
    logic [TICK_W-1:0] nxt_tick_cnt;
    logic tick_ff;
    logic nxt_tick;

    always_comb begin
        nxt_tick = (tick_cnt_ff == TICK_CYC - TICK_W'(1));
        nxt_tick_cnt = nxt_tick ? '0 : tick_cnt_ff + TICK_W'(1);
    end

    always_ff @(posedge i_sys_clk or negedge i_nrst) begin
        if (!i_nrst) begin
            tick_cnt_ff <= '0;
            tick_ff <= 1'b0;
        end else begin
            tick_cnt_ff <= nxt_tick_cnt;
            tick_ff <= nxt_tick;
        end
    end

    // ------------------------------------------------------------
    // button synchroniser
    // ------------------------------------------------------------
    logic [1:0] btn_s1_ff;
    logic [1:0] btn_s2_ff;

    always_ff @(posedge i_sys_clk or negedge i_nrst) begin
        if (!i_nrst) begin
            btn_s1_ff <= 2'h3;
            btn_s2_ff <= 2'h3;
        end else begin
            btn_s1_ff <= i_btn_n;
            btn_s2_ff <= btn_s1_ff;
        end
    end

    // ------------------------------------------------------------
    // persistence timers
    // ------------------------------------------------------------
    logic hold_done;
    logic vunb_exp;
    logic cunb_exp;
    logic ecu_exp;
    logic spd_exp;
    logic btn_exp;
    logic both_btn;
    logic oc_any;

    assign both_btn = (btn_s2_ff == 2'h0);
    assign oc_any = (excess(i_ph_curr, i_oc_thr) != '0);

    gsf_persist u_hold (
        .i_sys_clk(i_sys_clk),
        .i_nrst(i_nrst),
        .i_tick(tick_ff),
        .i_cond(i_eng_running),
        .i_limit(i_holdoff_ms),
        .o_done(hold_done)
    );

    gsf_persist u_vunb (
        .i_sys_clk(i_sys_clk),
        .i_nrst(i_nrst),
        .i_tick(tick_ff),
        .i_cond(hold_done && dev_over(i_ph_volt, i_dev_lim)),
        .i_limit(i_unbal_ms),
        .o_done(vunb_exp)
    );

    gsf_persist u_cunb (
        .i_sys_clk(i_sys_clk),
        .i_nrst(i_nrst),
        .i_tick(tick_ff),
        .i_cond(hold_done && dev_over(i_ph_curr, i_dev_lim)),
        .i_limit(i_unbal_ms),
        .o_done(cunb_exp)
    );

    // a message drops the condition for a cycle and restarts the count
    gsf_persist u_ecu (
        .i_sys_clk(i_sys_clk),
        .i_nrst(i_nrst),
        .i_tick(tick_ff),
        .i_cond(i_fuel_on && !i_ecu_msg),
        .i_limit(TMR_W'(ECU_TIMEOUT_MS)),
        .o_done(ecu_exp)
    );

    gsf_persist u_spd (
        .i_sys_clk(i_sys_clk),
        .i_nrst(i_nrst),
        .i_tick(tick_ff),
        .i_cond(i_fuel_on && (i_rpm < i_crank_cut_rpm)),
        .i_limit(i_spd_loss_ms),
        .o_done(spd_exp)
    );

    gsf_persist u_btn (
        .i_sys_clk(i_sys_clk),
        .i_nrst(i_nrst),
        .i_tick(tick_ff),
        .i_cond(both_btn),
        .i_limit(TMR_W'(BTN_HOLD_MS)),
        .o_done(btn_exp)
    );

    // ------------------------------------------------------------
    // overcurrent inverse-time accumulator and start attempts
    // ------------------------------------------------------------
    logic [ACC_W-1:0] oc_acc_ff;
    logic [ACC_W-1:0] nxt_oc_acc;
    logic [ATT_W-1:0] att_ff;
    logic [ATT_W-1:0] nxt_att;
    logic [ACC_W:0] oc_sum;

    always_comb begin
        oc_sum = (ACC_W+1)'(oc_acc_ff)
               + (ACC_W+1)'(excess(i_ph_curr, i_oc_thr));
        nxt_oc_acc = oc_acc_ff;
        if (!oc_any) begin
            nxt_oc_acc = ACC_RST;
        end else if (tick_ff) begin
            nxt_oc_acc = oc_sum[ACC_W] ? '1 : oc_sum[ACC_W-1:0];
        end
        nxt_att = att_ff;
        if (i_eng_running || i_alarm_clr) begin
            nxt_att = ATT_RST;
        end else if (i_crank_end && att_ff != '1) begin
            nxt_att = att_ff + ATT_W'(1);
        end
    end

    always_ff @(posedge i_sys_clk or negedge i_nrst) begin
        if (!i_nrst) begin
            oc_acc_ff <= ACC_RST;
            att_ff <= ATT_RST;
        end else begin
            oc_acc_ff <= nxt_oc_acc;
            att_ff <= nxt_att;
        end
    end

    // ------------------------------------------------------------
    // sticky alarms and fault actions
    // ------------------------------------------------------------
    gsf_alarm_s alarm_ff;
    gsf_alarm_s nxt_alarm;
    logic warn_ff;
    logic nxt_warn;
    logic dump_ff;
    logic nxt_dump;
    logic stop_ff;
    logic nxt_stop;

    function automatic logic act_is(
        input logic flag,
        input gsf_act_e act,
        input gsf_act_e want
    );
        act_is = flag && (act == want);
    endfunction

    always_comb begin
        nxt_alarm = i_alarm_clr ? ALARM_RST : alarm_ff;
        // sets follow the clear so a same-cycle event is kept
        if (hold_done && i_chg_volt < i_chg_low_lim) begin
            nxt_alarm.chg_low = 1'b1;
        end
        if (ecu_exp) begin
            nxt_alarm.ecu_fail = 1'b1;
        end
        if (vunb_exp) begin
            nxt_alarm.volt_unbal = 1'b1;
        end
        if (cunb_exp) begin
            nxt_alarm.curr_unbal = 1'b1;
        end
        if (oc_any && oc_acc_ff >= i_oc_curve) begin
            nxt_alarm.overcurr = 1'b1;
        end
        if (spd_exp) begin
            nxt_alarm.spd_loss = 1'b1;
        end
        if (!i_eng_running && i_start_max != ATT_RST
                && att_ff >= i_start_max) begin
            nxt_alarm.start_fail = 1'b1;
        end
        if (|i_svc_expired) begin
            nxt_alarm.svc_req = 1'b1;
        end
        nxt_warn = alarm_ff.chg_low || alarm_ff.ecu_fail
                || alarm_ff.volt_unbal || alarm_ff.svc_req
                || act_is(alarm_ff.curr_unbal, i_act_cunb, ACT_WARN)
                || act_is(alarm_ff.overcurr, i_act_oc, ACT_WARN)
                || act_is(alarm_ff.spd_loss, i_act_spd, ACT_WARN);
        nxt_dump = act_is(alarm_ff.curr_unbal, i_act_cunb, ACT_DUMP)
                || act_is(alarm_ff.overcurr, i_act_oc, ACT_DUMP)
                || act_is(alarm_ff.spd_loss, i_act_spd, ACT_DUMP);
        nxt_stop = alarm_ff.start_fail
                || act_is(alarm_ff.curr_unbal, i_act_cunb, ACT_STOP)
                || act_is(alarm_ff.overcurr, i_act_oc, ACT_STOP)
                || act_is(alarm_ff.spd_loss, i_act_spd, ACT_STOP);
    end

    always_ff @(posedge i_sys_clk or negedge i_nrst) begin
        if (!i_nrst) begin
            alarm_ff <= ALARM_RST;
            warn_ff <= 1'b0;
            dump_ff <= 1'b0;
            stop_ff <= 1'b0;
        end else begin
            alarm_ff <= nxt_alarm;
            warn_ff <= nxt_warn;
            dump_ff <= nxt_dump;
            stop_ff <= nxt_stop;
        end
    end

    // ------------------------------------------------------------
    // service counter reset: one pulse per button hold
    // ------------------------------------------------------------
    gsf_btn_e btn_st_ff;
    gsf_btn_e nxt_btn_st;
    logic svc_clr_ff;
    logic nxt_svc_clr;

    always_comb begin
        nxt_btn_st = btn_st_ff;
        unique case (btn_st_ff)
            BTN_IDLE: begin
                if (btn_exp) begin
                    nxt_btn_st = BTN_FIRE;
                end
            end
            BTN_FIRE: begin
                nxt_btn_st = BTN_WAIT;
            end
            BTN_WAIT: begin
                if (!both_btn) begin
                    nxt_btn_st = BTN_IDLE;
                end
            end
            default: begin
                nxt_btn_st = BTN_IDLE;
            end
        endcase
        nxt_svc_clr = (nxt_btn_st == BTN_FIRE);
    end

    always_ff @(posedge i_sys_clk or negedge i_nrst) begin
        if (!i_nrst) begin
            btn_st_ff <= BTN_IDLE;
            svc_clr_ff <= 1'b0;
        end else begin
            btn_st_ff <= nxt_btn_st;
            svc_clr_ff <= nxt_svc_clr;
        end
    end

    assign o_alarm = alarm_ff;
    assign o_warning = warn_ff;
    assign o_load_dump = dump_ff;
    assign o_shutdown = stop_ff;
    assign o_svc_clear = svc_clr_ff;

    // ------------------------------------------------------------
    // checks
    // ------------------------------------------------------------
    chg_low_a: assert property (
        @(posedge i_sys_clk) disable iff (!i_nrst)
        hold_done && (i_chg_volt < i_chg_low_lim) |=> o_alarm.chg_low)
        else $error("low charge alarm missed");

    chg_holdoff_a: assert property (
        @(posedge i_sys_clk) disable iff (!i_nrst)
        $rose(o_alarm.chg_low) |-> $past(hold_done))
        else $error("charge alarm before holdoff");

    ecu_set_a: assert property (
        @(posedge i_sys_clk) disable iff (!i_nrst)
        ecu_exp |=> o_alarm.ecu_fail)
        else $error("engine unit fail alarm missed");

    ecu_fuel_a: assert property (
        @(posedge i_sys_clk) disable iff (!i_nrst)
        $rose(o_alarm.ecu_fail) |-> $past(i_fuel_on, 2))
        else $error("engine unit fail without fuel");

    vunb_set_a: assert property (
        @(posedge i_sys_clk) disable iff (!i_nrst)
        $rose(o_alarm.volt_unbal) |-> $past(vunb_exp))
        else $error("voltage unbalance without persistence");

    oc_clear_a: assert property (
        @(posedge i_sys_clk) disable iff (!i_nrst)
        !oc_any |=> (oc_acc_ff == ACC_RST))
        else $error("overcurrent accumulator kept");

    oc_set_a: assert property (
        @(posedge i_sys_clk) disable iff (!i_nrst)
        oc_any && (oc_acc_ff >= i_oc_curve) |=> o_alarm.overcurr)
        else $error("overcurrent alarm missed");

    oc_action_a: assert property (
        @(posedge i_sys_clk) disable iff (!i_nrst)
        o_alarm.overcurr && (i_act_oc == ACT_STOP) |=> o_shutdown)
        else $error("overcurrent stop action missed");

    alarm_sticky_a: assert property (
        @(posedge i_sys_clk) disable iff (!i_nrst)
        o_alarm.chg_low && !i_alarm_clr |=> o_alarm.chg_low)
        else $error("alarm dropped without clear");

    svc_req_a: assert property (
        @(posedge i_sys_clk) disable iff (!i_nrst)
        (|i_svc_expired) |=> o_alarm.svc_req)
        else $error("service request missed");

    svc_pulse_a: assert property (
        @(posedge i_sys_clk) disable iff (!i_nrst)
        o_svc_clear |=> !o_svc_clear)
        else $error("service clear longer than a cycle");

endmodule // gsf_supervisor
`default_nettype wire

// ==== verif/gsf_engine_model.sv ====
// far-side model: engine unit messages, speed pickup and panel buttons
`timescale 1ns/100ps
`default_nettype none
module gsf_engine_model
    import gsf_pkg::*;
#(
    parameter int MSG_GAP = 4000,
    parameter logic [MEAS_W-1:0] RUN_RPM = 16'h05DC
) (
    input wire logic i_sys_clk,
    input wire logic i_nrst,
    input wire logic i_msg_en,
    input wire logic i_turning,
    input wire logic i_press,
    output logic o_ecu_msg,
    output logic [MEAS_W-1:0] o_rpm,
    output logic [1:0] o_btn_n
);
    int gap_cnt;

    // one-cycle message pulse every MSG_GAP cycles while enabled
    always @(posedge i_sys_clk or negedge i_nrst) begin
        if (!i_nrst) begin
            gap_cnt <= 0;
            o_ecu_msg <= 1'b0;
            o_rpm <= '0;
            o_btn_n <= 2'h3;
        end else begin
            gap_cnt <= (i_msg_en && gap_cnt < MSG_GAP - 1) ? gap_cnt + 1 : 0;
            o_ecu_msg <= i_msg_en && (gap_cnt == MSG_GAP - 1);
            o_rpm <= i_turning ? RUN_RPM : '0;
            // both keys pressed together; released keys idle high
            o_btn_n <= i_press ? 2'h0 : 2'h3;
        end
    end
endmodule // gsf_engine_model
`default_nettype wire

// ==== verif/testbench.sv ====
// self-checking bench for the genset fault supervisor
`timescale 1ns/100ps
`default_nettype none
module testbench
    import gsf_pkg::*;
;
    localparam int T = 4;
    logic i_sys_clk = 1'b0, i_nrst = 1'b0, i_alarm_clr = 1'b0;
    logic i_eng_running = 1'b0, i_fuel_on = 1'b0, i_crank_end = 1'b0;
    logic msg_en = 1'b0, turning = 1'b0, press = 1'b0;
    logic i_ecu_msg;
    logic [1:0] i_btn_n;
    logic [MEAS_W-1:0] i_rpm;
    logic [MEAS_W-1:0] i_chg_volt = 16'h04B0, i_chg_low_lim = 16'h03E8;
    logic [MEAS_W-1:0] i_dev_lim = 16'h0014, i_oc_thr = 16'h0064;
    logic [MEAS_W-1:0] i_crank_cut_rpm = 16'h0190;
    logic [ACC_W-1:0] i_oc_curve = 32'h000000C8;
    logic [TMR_W-1:0] i_holdoff_ms = 16'h000A, i_unbal_ms = 16'h0003;
    logic [TMR_W-1:0] i_spd_loss_ms = 16'h0005;
    logic [ATT_W-1:0] i_start_max = 4'h2;
    logic [SVC_N-1:0] i_svc_expired = 3'h0;
    gsf_phase_s i_ph_volt = {3{16'h00E6}}, i_ph_curr = {3{16'h0032}};
    gsf_act_e i_act_cunb = ACT_NONE, i_act_oc = ACT_NONE;
    gsf_act_e i_act_spd = ACT_NONE;
    gsf_alarm_s o_alarm;
    logic o_warning, o_load_dump, o_shutdown, o_svc_clear;
    int bad_count = 0, total_checks = 0, pulses = 0, cycles = 0;

    gsf_supervisor #(.TICK_CYC(TICK_W'(T))) dut (
        .i_sys_clk(i_sys_clk),
        .i_nrst(i_nrst),
        .i_alarm_clr(i_alarm_clr),
        .i_eng_running(i_eng_running),
        .i_fuel_on(i_fuel_on),
        .i_ecu_msg(i_ecu_msg),
        .i_crank_end(i_crank_end),
        .i_chg_volt(i_chg_volt),
        .i_chg_low_lim(i_chg_low_lim),
        .i_ph_volt(i_ph_volt),
        .i_ph_curr(i_ph_curr),
        .i_dev_lim(i_dev_lim),
        .i_oc_thr(i_oc_thr),
        .i_oc_curve(i_oc_curve),
        .i_rpm(i_rpm),
        .i_crank_cut_rpm(i_crank_cut_rpm),
        .i_holdoff_ms(i_holdoff_ms),
        .i_unbal_ms(i_unbal_ms),
        .i_spd_loss_ms(i_spd_loss_ms),
        .i_start_max(i_start_max),
        .i_svc_expired(i_svc_expired),
        .i_btn_n(i_btn_n),
        .i_act_cunb(i_act_cunb),
        .i_act_oc(i_act_oc),
        .i_act_spd(i_act_spd),
        .o_alarm(o_alarm),
        .o_warning(o_warning),
        .o_load_dump(o_load_dump),
        .o_shutdown(o_shutdown),
        .o_svc_clear(o_svc_clear)
    );
    gsf_engine_model #(.MSG_GAP(1000 * T)) far (
        .i_sys_clk(i_sys_clk),
        .i_nrst(i_nrst),
        .i_msg_en(msg_en),
        .i_turning(turning),
        .i_press(press),
        .o_ecu_msg(i_ecu_msg),
        .o_rpm(i_rpm),
        .o_btn_n(i_btn_n)
    );

    always #10 i_sys_clk = ~i_sys_clk;

    // watchdog and service clear pulse counter
    always @(posedge i_sys_clk) begin
        cycles++;
        if (o_svc_clear === 1'b1) pulses++;
        if (cycles == 70000) begin
            bad_count++;
            wrap_up();
        end
    end

    task automatic cyc(input int n);
        repeat (n) @(negedge i_sys_clk);
    endtask

    task automatic ms(input int n);
        cyc(n * T);
    endtask

    task automatic chk(input string what, input logic [7:0] exp,
                       input logic [7:0] got);
        total_checks++;
        if (got !== exp) begin
            bad_count++;
            $display("Error %s expected %h seen %h", what, exp, got);
        end
    endtask

    task automatic chk_cnt(input string what, input int exp, input int got);
        total_checks++;
        if (got != exp) begin
            bad_count++;
            $display("Error %s expected %0d seen %0d", what, exp, got);
        end
    endtask

    // two clear cycles: only a cause still seen at the second one sets again
    task automatic clr();
        i_alarm_clr = 1'b1;
        cyc(2);
        i_alarm_clr = 1'b0;
        cyc(3);
    endtask

    task automatic crank();
        i_crank_end = 1'b1;
        cyc(1);
        i_crank_end = 1'b0;
        cyc(3);
    endtask

    task automatic wrap_up();
        $display("checks %0d errors %0d", total_checks, bad_count);
        if (bad_count == 0 && total_checks > 0) begin
            $display("ALL TESTS PASSED");
        end else begin
            $display("TESTS FAILED");
        end
        $finish;
    endtask

    // --------
    // scenarios
    // --------
    initial begin
        cyc(3);
        i_nrst = 1'b1;
        cyc(2);
        chk("alarms", 8'h00, o_alarm);
        crank();
        chk("start_fail", 8'h00, o_alarm.start_fail);
        crank();
        cyc(1);
        chk("start_fail", 8'h01, o_alarm.start_fail);
        chk("shutdown", 8'h01, o_shutdown);
        clr();
        chk("alarms", 8'h00, o_alarm);
        // charge check held off after start
        i_eng_running = 1'b1;
        turning = 1'b1;
        i_chg_volt = 16'h0384;
        cyc(30);
        chk("chg_low", 8'h00, o_alarm.chg_low);
        cyc(20);
        chk("chg_low", 8'h01, o_alarm.chg_low);
        i_chg_volt = 16'h04B0;
        cyc(5);
        chk("chg_low", 8'h01, o_alarm.chg_low);
        chk("warning", 8'h01, o_warning);
        clr();
        // short unbalance bursts must not add up
        repeat (2) begin
            i_ph_volt.l1 = 16'h012C;
            cyc(6);
            i_ph_volt.l1 = 16'h00E6;
            cyc(8);
        end
        chk("volt_unbal", 8'h00, o_alarm.volt_unbal);
        i_ph_volt.l1 = 16'h012C;
        cyc(20);
        chk("volt_unbal", 8'h01, o_alarm.volt_unbal);
        i_ph_volt.l1 = 16'h00E6;
        clr();
        i_ph_curr.l1 = 16'h005A;
        cyc(20);
        chk("curr_unbal", 8'h01, o_alarm.curr_unbal);
        for (int a = 0; a < 4; a++) begin
            i_act_cunb = gsf_act_e'(a);
            cyc(3);
            chk("warning", 8'(a == 1), o_warning);
            chk("shutdown", 8'(a == 2), o_shutdown);
            chk("load_dump", 8'(a == 3), o_load_dump);
        end
        i_ph_curr.l1 = 16'h0032;
        i_act_cunb = ACT_NONE;
        clr();
        // small excess twice with a dip between, then large excess
        i_act_oc = ACT_STOP;
        repeat (2) begin
            i_ph_curr = {3{16'h006E}};
            ms(15);
            chk("overcurr", 8'h00, o_alarm.overcurr);
            i_ph_curr = {3{16'h0032}};
            cyc(8);
        end
        i_ph_curr = {3{16'h00C8}};
        cyc(20);
        chk("overcurr", 8'h01, o_alarm.overcurr);
        chk("shutdown", 8'h01, o_shutdown);
        i_ph_curr = {3{16'h0032}};
        i_act_oc = ACT_NONE;
        clr();
        i_fuel_on = 1'b1;
        i_act_spd = ACT_DUMP;
        turning = 1'b0;
        cyc(12);
        chk("spd_loss", 8'h00, o_alarm.spd_loss);
        cyc(18);
        chk("spd_loss", 8'h01, o_alarm.spd_loss);
        chk("load_dump", 8'h01, o_load_dump);
        turning = 1'b1;
        i_fuel_on = 1'b0;
        i_act_spd = ACT_NONE;
        clr();
        // service request and button hold, fuel off throughout
        i_svc_expired = 3'h2;
        cyc(3);
        chk("svc_req", 8'h01, o_alarm.svc_req);
        press = 1'b1;
        ms(1000);
        press = 1'b0;
        ms(2);
        chk_cnt("svc_clear", 0, pulses);
        press = 1'b1;
        ms(4990);
        chk_cnt("svc_clear", 0, pulses);
        ms(20);
        press = 1'b0;
        ms(2);
        chk_cnt("svc_clear", 1, pulses);
        chk("ecu_fail", 8'h00, o_alarm.ecu_fail);
        i_svc_expired = 3'h0;
        clr();
        chk("svc_req", 8'h00, o_alarm.svc_req);
        // messages keep the engine unit alive, silence trips it
        i_fuel_on = 1'b1;
        msg_en = 1'b1;
        ms(3500);
        chk("ecu_fail", 8'h00, o_alarm.ecu_fail);
        @(posedge i_ecu_msg);
        cyc(1);
        msg_en = 1'b0;
        ms(2900);
        chk("ecu_fail", 8'h00, o_alarm.ecu_fail);
        ms(200);
        chk("ecu_fail", 8'h01, o_alarm.ecu_fail);
        chk("warning", 8'h01, o_warning);
        wrap_up();
    end
endmodule // testbench
`default_nettype wire
